// *** shared/fstc_pkg.sv ***
// fstc_pkg: constants and enumerations for the frame start trigger control
// assumes a 50 MHz system clock; periods are expressed in clock cycles
package fstc_pkg;
	localparam int FSTC_PERIOD_W = 32;
	localparam int FSTC_EXP_W = 32;
	// trigger mode encodings
	localparam logic FSTC_MODE_OFF = 1'h0;
	localparam logic FSTC_MODE_ON = 1'h1;
	// acquisition mode encodings
	localparam logic FSTC_ACQ_SINGLE = 1'h0;
	localparam logic FSTC_ACQ_CONT = 1'h1;
	// trigger source encodings, line 1 is the reset value
	localparam logic FSTC_SRC_SOFTWARE = 1'h0;
	localparam logic FSTC_SRC_LINE1 = 1'h1;
	localparam logic FSTC_SRC_RESET = FSTC_SRC_LINE1;
	// edge selection encodings
	localparam logic FSTC_EDGE_RISING = 1'h0;
	localparam logic FSTC_EDGE_FALLING = 1'h1;
	// exposure source encodings
	localparam logic FSTC_EXPO_TIMED = 1'h0;
	localparam logic FSTC_EXPO_WIDTH = 1'h1;
	localparam logic [FSTC_EXP_W-1:0] FSTC_EXP_MIN = 32'h0000_0001;
	typedef enum logic [1:0] {
		FSTC_IDLE = 2'b00,
		FSTC_WAIT = 2'b01,
		FSTC_EXPOSE = 2'b10
	} fstc_state_t;
endpackage

// *** verilog/fstc_edge_detect.sv ***
// fstc_edge_detect: synchronises input line 1 and flags the selected edge
// assumes line_in is asynchronous to clock
`timescale 1ns/1ps
module fstc_edge_detect
	import fstc_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// line and edge choice
	input wire logic line_in,
	input wire logic falling_sel,
	// result
	output logic level,
	output logic edge_pulse
);
	logic meta_r;
	logic sync_r;
	logic prev_r;
	logic [1:0] fill_r;

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			meta_r <= 1'h0;
			sync_r <= 1'h0;
			prev_r <= 1'h0;
		end
		else
		begin
			meta_r <= line_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// no edge until prev_r holds a real sample: a line idling high
	// would otherwise look like a rising edge just after reset
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			fill_r <= 2'h0;
		else if (fill_r != 2'h3)
			fill_r <= fill_r + 2'h1;
	end

	assign level = sync_r;
	// one-cycle pulse on the chosen transition
	assign edge_pulse = (fill_r == 2'h3) && ((falling_sel == FSTC_EDGE_FALLING)
		? (prev_r & ~sync_r) : (~prev_r & sync_r));

	rising_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
		(fill_r == 2'h3 && falling_sel == FSTC_EDGE_RISING && $rose(sync_r))
		|-> edge_pulse)
		else $error("rising edge not flagged");
	single_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
		edge_pulse |=> !edge_pulse)
		else $error("edge pulse longer than one cycle");
endmodule

// *** verilog/fstc_top.sv ***
// fstc_top: frame start trigger control, decides when each exposure begins
// assumes command inputs are one-cycle pulses from logic on the same clock;
// max_period is supplied by the frame rate calculator outside this block
`timescale 1ns/1ps

module fstc_top
	import fstc_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// acquisition commands and settings
	input wire logic acq_mode_valid,
	input wire logic acq_mode,
	input wire logic acq_start_cmd,
	input wire logic acq_stop_cmd,
	input wire logic acq_start_trig_enable,
	input wire logic acq_start_trig,
	// frame start trigger settings
	input wire logic trigger_mode,
	input wire logic source_wr,
	input wire logic source_wdata,
	input wire logic edge_sel,
	input wire logic exposure_sel,
	input wire logic software_trig,
	input wire logic line1_in,
	// timing settings in clock cycles
	input wire logic frame_rate_limit_enable,
	input wire logic [FSTC_PERIOD_W-1:0] rate_period,
	input wire logic [FSTC_PERIOD_W-1:0] max_period,
	input wire logic [FSTC_EXP_W-1:0] exposure_time,
	// status and events
	output logic trigger_source,
	output logic waiting_frame_start,
	output logic exposing,
	output logic frame_start,
	output logic overtrigger
);
	fstc_state_t state_r;
	fstc_state_t state_nxt;
	logic source_r;
	logic armed_r;
	logic line_level;
	logic line_edge;
	logic [FSTC_PERIOD_W-1:0] period_cnt_r;
	logic [FSTC_EXP_W-1:0] exp_cnt_r;
	logic width_mode_r;
	logic start_seen_r;
	logic stop_seen_r;
	logic [FSTC_PERIOD_W-1:0] eff_period;
	logic int_trig;
	logic ext_trig;
	logic trig;
	logic accept;
	logic exp_done;
	logic wait_r;
	logic expo_r;
	logic fs_r;
	logic ovr_r;

	fstc_edge_detect u_edge
	(
		.clock(clock),
		.rst_n(rst_n),
		.line_in(line1_in),
		.falling_sel(edge_sel),
		.level(line_level),
		.edge_pulse(line_edge)
	);

	// source setting, line 1 after reset
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			source_r <= FSTC_SRC_RESET;
		else if (source_wr)
			source_r <= source_wdata;
	end

	// remembers a start command until the start trigger arrives
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			start_seen_r <= 1'h0;
		else if (acq_stop_cmd || state_r != FSTC_IDLE)
			start_seen_r <= 1'h0;
		else if (acq_start_cmd && acq_mode_valid)
			start_seen_r <= 1'h1;
	end

	// a stop during an exposure is held until that exposure ends
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			stop_seen_r <= 1'h0;
		else if (state_r == FSTC_IDLE)
			stop_seen_r <= 1'h0;
		else if (acq_stop_cmd)
			stop_seen_r <= 1'h1;
	end

	// larger period means slower rate; clamp to the maximum permitted rate
	always_comb
	begin
		if (frame_rate_limit_enable && rate_period > max_period)
			eff_period = rate_period;
		else
			eff_period = max_period;
	end

	// internal trigger when mode off and the period has elapsed
	assign int_trig = (trigger_mode == FSTC_MODE_OFF) && armed_r
		&& (period_cnt_r == '0);
	assign ext_trig = (trigger_mode == FSTC_MODE_ON) && ((source_r == FSTC_SRC_SOFTWARE)
		? software_trig : line_edge);
	assign trig = int_trig || ext_trig;
	assign accept = trig && state_r == FSTC_WAIT;
	assign exp_done = width_mode_r ? (line_level == edge_sel) : (exp_cnt_r <= FSTC_EXP_MIN);

	// armed while internal triggers are still owed
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			armed_r <= 1'h0;
		else if (acq_stop_cmd)
			armed_r <= 1'h0;
		else if (state_r == FSTC_IDLE && state_nxt == FSTC_WAIT)
			armed_r <= 1'h1;
		else if (accept && int_trig && acq_mode == FSTC_ACQ_SINGLE)
			armed_r <= 1'h0;
	end

	// spacing counter between internal triggers
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			period_cnt_r <= '0;
		else if (accept)
			period_cnt_r <= eff_period - 32'h0000_0001;
		else if (period_cnt_r != '0)
			period_cnt_r <= period_cnt_r - 32'h0000_0001;
	end

	// exposure timing: programmed time or the trigger pulse width
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			exp_cnt_r <= '0;
			width_mode_r <= 1'h0;
		end
		else if (accept)
		begin
			exp_cnt_r <= exposure_time;
			width_mode_r <= (trigger_mode == FSTC_MODE_ON) && (source_r == FSTC_SRC_LINE1)
				&& (exposure_sel == FSTC_EXPO_WIDTH);
		end
		else if (exp_cnt_r != '0)
			exp_cnt_r <= exp_cnt_r - 32'h0000_0001;
	end

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			FSTC_IDLE:
				if (start_seen_r && acq_mode_valid && !acq_stop_cmd
					&& (!acq_start_trig_enable || acq_start_trig))
					state_nxt = FSTC_WAIT;
			// accepted trigger wins over a stop, so every frame_start gets its exposure
			FSTC_WAIT:
				if (accept)
					state_nxt = FSTC_EXPOSE;
				else if (acq_stop_cmd)
					state_nxt = FSTC_IDLE;
			FSTC_EXPOSE:
				if (exp_done)
					state_nxt = (acq_stop_cmd || stop_seen_r
						|| (trigger_mode == FSTC_MODE_OFF && !armed_r))
						? FSTC_IDLE : FSTC_WAIT;
			default:
				state_nxt = FSTC_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			state_r <= FSTC_IDLE;
		else
			state_r <= state_nxt;
	end

	// registered outputs; late triggers are dropped, external ones during exposure flagged
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			wait_r <= 1'h0;
			expo_r <= 1'h0;
			fs_r <= 1'h0;
			ovr_r <= 1'h0;
		end
		else
		begin
			wait_r <= state_nxt == FSTC_WAIT;
			expo_r <= state_nxt == FSTC_EXPOSE;
			fs_r <= accept;
			ovr_r <= ext_trig && state_r == FSTC_EXPOSE;
		end
	end

	assign trigger_source = source_r;
	assign waiting_frame_start = wait_r;
	assign exposing = expo_r;
	assign frame_start = fs_r;
	assign overtrigger = ovr_r;

	accept_frame_a: assert property (@(posedge clock) disable iff (!rst_n)
		(trig && state_r == FSTC_WAIT) |=> frame_start && exposing)
		else $error("accepted trigger did not start a frame");
	wait_needs_start_a: assert property (@(posedge clock) disable iff (!rst_n)
		(state_r == FSTC_IDLE && state_nxt == FSTC_WAIT) |-> start_seen_r)
		else $error("waiting entered without start command");
	discard_trig_a: assert property (@(posedge clock) disable iff (!rst_n)
		(state_r != FSTC_WAIT) |=> !frame_start)
		else $error("trigger accepted outside waiting");
	overtrig_a: assert property (@(posedge clock) disable iff (!rst_n)
		(ext_trig && state_r == FSTC_EXPOSE) |=> overtrigger && !frame_start)
		else $error("overtrigger not raised");
	leave_wait_a: assert property (@(posedge clock) disable iff (!rst_n)
		accept |=> !waiting_frame_start)
		else $error("waiting held during exposure");
	source_reset_a: assert property (@(posedge clock)
		!rst_n |=> trigger_source == FSTC_SRC_LINE1)
		else $error("source not line 1 after reset");
	single_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
		(accept && int_trig && acq_mode == FSTC_ACQ_SINGLE && !acq_stop_cmd) |=> !armed_r)
		else $error("single frame kept triggering");
	stop_cmd_a: assert property (@(posedge clock) disable iff (!rst_n)
		acq_stop_cmd |=> !armed_r)
		else $error("triggers continue after stop");
	rate_clamp_a: assert property (@(posedge clock) disable iff (!rst_n)
		(accept && !frame_rate_limit_enable) |=> period_cnt_r == $past(max_period) - 1)
		else $error("period not at maximum rate");
	sw_source_a: assert property (@(posedge clock) disable iff (!rst_n)
		(trigger_mode && source_r == FSTC_SRC_SOFTWARE && line_edge && !software_trig)
		|-> !ext_trig)
		else $error("line edge used while source is software");

	internal_cv: cover property (@(posedge clock) disable iff (!rst_n) accept && int_trig);
	software_cv: cover property (@(posedge clock) disable iff (!rst_n)
		accept && trigger_mode && source_r == FSTC_SRC_SOFTWARE);
	line_cv: cover property (@(posedge clock) disable iff (!rst_n) accept && line_edge);
	overtrig_cv: cover property (@(posedge clock) disable iff (!rst_n) overtrigger);
endmodule

// *** tb/fstc_line_src.sv ***
// fstc_line_src: model of the external trigger source on input line 1
// assumes the bench calls its tasks at rising edges of the block clock
`timescale 1ns/1ps
module fstc_line_src
(
	// clock
	input wire logic clock,
	// driven line
	output logic line_out
);
	initial line_out = 1'h0;
	// park the line at its idle level, then let the synchroniser settle
	task automatic rest(input logic idle);
		@(posedge clock);
		line_out <= idle;
		repeat (4) @(posedge clock);
	endtask
	// one separate pulse for every frame wanted
	task automatic pulse(input logic active, input int width);
		line_out <= active;
		repeat (width) @(posedge clock);
		line_out <= ~active;
	endtask
endmodule

// *** tb/tb_fstc_top.sv ***
// tb_fstc_top: self-checking bench for the frame start trigger control
// assumes the line 1 source model and the design sources are compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
	$display("BAD %0t got %0h want %0h", $time, a, b); end end
module tb_fstc_top
	import fstc_pkg::*;
;
	logic clock, rst_n, acq_mode_valid, acq_mode, acq_start_cmd, acq_stop_cmd;
	logic acq_start_trig_enable, acq_start_trig, trigger_mode, source_wr, source_wdata;
	logic edge_sel, exposure_sel, software_trig, frame_rate_limit_enable;
	logic [FSTC_PERIOD_W-1:0] rate_period, max_period;
	logic [FSTC_EXP_W-1:0] exposure_time;
	logic trigger_source, waiting_frame_start, exposing, frame_start, overtrigger;
	wire logic line1_in;
	int mismatches = 0, check_count = 0, cyc = 0, run = 0, exp_len = 0;
	int ovt_seen = 0, ovt_want = 0, e = 0, per = 0, seed = 38154, want_cyc = 0;
	int exp_q[$];

	fstc_top dut_u (.clock(clock), .rst_n(rst_n), .acq_mode_valid(acq_mode_valid),
		.acq_mode(acq_mode), .acq_start_cmd(acq_start_cmd), .acq_stop_cmd(acq_stop_cmd),
		.acq_start_trig_enable(acq_start_trig_enable), .acq_start_trig(acq_start_trig),
		.trigger_mode(trigger_mode), .source_wr(source_wr), .source_wdata(source_wdata),
		.edge_sel(edge_sel), .exposure_sel(exposure_sel), .software_trig(software_trig),
		.line1_in(line1_in), .frame_rate_limit_enable(frame_rate_limit_enable),
		.rate_period(rate_period), .max_period(max_period), .exposure_time(exposure_time),
		.trigger_source(trigger_source), .waiting_frame_start(waiting_frame_start),
		.exposing(exposing), .frame_start(frame_start), .overtrigger(overtrigger));
	fstc_line_src src_u (.clock(clock), .line_out(line1_in));

	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock) cyc <= cyc + 1;

	task automatic end_sim();
		`CHK(exp_q.size(), 0)
		`CHK(ovt_seen, ovt_want)
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock);
	endtask
	// notes each expected frame start cycle for the watcher
	task automatic start_acq(input logic mode, input int p, input int cnt);
		@(posedge clock);
		acq_mode <= mode;
		acq_start_cmd <= 1'h1;
		for (int k = 0; k < cnt; k++)
			exp_q.push_back(cyc + 4 + k * p);
		@(posedge clock);
		acq_start_cmd <= 1'h0;
	endtask
	task automatic stop_acq();
		@(posedge clock);
		acq_stop_cmd <= 1'h1;
		@(posedge clock);
		acq_stop_cmd <= 1'h0;
	endtask
	// kind 0 dropped, 1 starts a frame, 2 lands in an exposure
	task automatic sw_trig(input int kind);
		@(posedge clock);
		software_trig <= 1'h1;
		if (kind == 1)
			exp_q.push_back(cyc + 2);
		if (kind == 2)
			ovt_want++;
		@(posedge clock);
		software_trig <= 1'h0;
	endtask
	task automatic set_src(input logic v);
		@(posedge clock);
		source_wr <= 1'h1;
		source_wdata <= v;
		@(posedge clock);
		source_wr <= 1'h0;
		step(1);
		`CHK(trigger_source, v)
	endtask

	always @(posedge clock)
	begin
		if (rst_n === 1'b1)
		begin
			if (frame_start === 1'b1)
			begin
				if (exp_q.size() == 0)
					`CHK(frame_start, 1'b0)
				else
				begin
					want_cyc = exp_q.pop_front();
					`CHK(cyc, want_cyc)
				end
			end
			if (overtrigger === 1'b1)
				ovt_seen++;
			if (exposing === 1'b1)
			begin
				`CHK(waiting_frame_start, 1'b0)
				run++;
			end
			else if (run > 0)
			begin
				`CHK(run, exp_len)
				run = 0;
			end
		end
	end

	initial
	begin
		step(5000);
		mismatches++;
		end_sim();
	end

	initial
	begin
		rst_n = 1'b0;
		{acq_mode_valid, acq_mode, acq_start_cmd, acq_stop_cmd} = 4'h8;
		{acq_start_trig_enable, acq_start_trig, source_wr, source_wdata} = 4'h0;
		{edge_sel, exposure_sel, software_trig, frame_rate_limit_enable} = 4'h0;
		trigger_mode = FSTC_MODE_OFF;
		rate_period = 32'h0000_003C;
		max_period = 32'h0000_0028;
		e = 5 + ($random(seed) & 15);
		exposure_time = e;
		exp_len = e;
		step(6);
		rst_n <= 1'b1;
		step(1);
		`CHK(trigger_source, FSTC_SRC_RESET)
		// a start without a valid mode must not open waiting
		acq_mode_valid <= 1'h0;
		start_acq(FSTC_ACQ_SINGLE, 0, 0);
		step(5);
		`CHK(waiting_frame_start, 1'b0)
		acq_mode_valid <= 1'h1;
		start_acq(FSTC_ACQ_SINGLE, 0, 1);
		step(60);
		// limit off, slower limit kept, faster limit clamped
		for (int i = 0; i < 3; i++)
		begin
			per = (i == 1) ? 60 : 40;
			@(posedge clock);
			frame_rate_limit_enable <= (i != 0);
			rate_period <= (i == 2) ? 32'h0000_001E : 32'h0000_003C;
			start_acq(FSTC_ACQ_CONT, per, 3);
			step(2 * per + 10);
			stop_acq();
			step(per + 20);
		end
		@(posedge clock);
		trigger_mode <= FSTC_MODE_ON;
		set_src(FSTC_SRC_SOFTWARE);
		sw_trig(0);
		@(posedge clock);
		acq_start_trig_enable <= 1'h1;
		start_acq(FSTC_ACQ_CONT, 0, 0);
		step(5);
		`CHK(waiting_frame_start, 1'b0)
		@(posedge clock);
		acq_start_trig <= 1'h1;
		@(posedge clock);
		acq_start_trig <= 1'h0;
		acq_start_trig_enable <= 1'h0;
		step(3);
		`CHK(waiting_frame_start, 1'b1)
		sw_trig(1);
		step(1);
		sw_trig(2);
		step(30);
		sw_trig(1);
		step(30);
		set_src(FSTC_SRC_LINE1);
		// rising timed, falling timed, rising with pulse width exposure
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clock);
			edge_sel <= (i == 1) ? FSTC_EDGE_FALLING : FSTC_EDGE_RISING;
			exposure_sel <= (i == 2) ? FSTC_EXPO_WIDTH : FSTC_EXPO_TIMED;
			src_u.rest(i == 1);
			exp_len = (i == 2) ? 12 : e;
			exp_q.push_back(cyc + 4);
			src_u.pulse(i != 1, 12);
			step(40);
		end
		stop_acq();
		step(20);
		`CHK(waiting_frame_start, 1'b0)
		end_sim();
	end
endmodule
